// ---- core/lirq_pkg.sv ----
// Constants shared by the loop-zero event status bank
package lirq_pkg;
    localparam int APB_AW = 16;
    localparam int APB_DW = 32;
    localparam int EV_W = 8;
    localparam int NUM_BANKS = 5;
    localparam int IDX_W = 14;
    localparam int PROF_COUNT = 6;
    localparam int PROF_SEL_W = 3;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LOCK = 14'h3010;
    localparam logic [IDX_W-1:0] IDX_STATE = 14'h3011;
    localparam logic [IDX_W-1:0] IDX_ACQ = 14'h3012;
    localparam logic [IDX_W-1:0] IDX_PROF = 14'h3013;
    localparam logic [IDX_W-1:0] IDX_ANA = 14'h3014;
    localparam logic [IDX_W-1:0] IDX_MASK_BASE = 14'h3020;
    localparam logic [IDX_W-1:0] IDX_CLR_BASE = 14'h3030;
    localparam logic [IDX_W-1:0] IDX_PEND = 14'h3040;

    // Bank order in the event array
    localparam int BANK_LOCK = 0;
    localparam int BANK_STATE = 1;
    localparam int BANK_ACQ = 2;
    localparam int BANK_PROF = 3;
    localparam int BANK_ANA = 4;

    // Lock event bits
    localparam int B_PH_LOCKED = 0;
    localparam int B_PH_UNLOCKED = 1;
    localparam int B_FR_LOCKED = 2;
    localparam int B_FR_UNLOCKED = 3;
    localparam int B_SLEW_ON = 4;
    localparam int B_SLEW_OFF = 5;
    localparam int B_CLAMP_ON = 6;
    localparam int B_CLAMP_OFF = 7;
    // State event bits
    localparam int B_PH_STEP = 0;
    localparam int B_HISTORY = 2;
    localparam int B_HITLESS_OFF = 3;
    localparam int B_HITLESS_ON = 4;
    localparam int B_HOLDOVER = 5;
    localparam int B_FREERUN = 6;
    localparam int B_REF_SWITCH = 7;
    // Acquisition event bits
    localparam int B_FAST_START = 2;
    localparam int B_FAST_DONE = 3;
    localparam int B_NDIV_RESYNC = 4;
    // Analog loop event bits
    localparam int B_CAL_START = 0;
    localparam int B_CAL_DONE = 1;
    localparam int B_ALOCK = 2;
    localparam int B_AUNLOCK = 3;
    localparam int B_DIST_SYNC = 4;

    // Implemented bits per bank; reserved bits stay zero
    localparam logic [EV_W-1:0] IMPL_LOCK = 8'hFF;
    localparam logic [EV_W-1:0] IMPL_STATE = 8'hFD;
    localparam logic [EV_W-1:0] IMPL_ACQ = 8'h1C;
    localparam logic [EV_W-1:0] IMPL_PROF = 8'h3F;
    localparam logic [EV_W-1:0] IMPL_ANA = 8'h1F;

    localparam logic [EV_W-1:0] EV_RESET = 8'h00;
    localparam logic [EV_W-1:0] MASK_RESET = 8'h00;
endpackage : lirq_pkg

// ---- core/lirq_event_bank.sv ----
// One eight-bit bank of sticky event flags
`timescale 1ns/1ps
module lirq_event_bank #(
    parameter int W = 8,
    parameter logic [W-1:0] IMPL = '1
) (
    input wire logic core_clk, // Core clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic [W-1:0] set_vec, // Event pulses
    input wire logic [W-1:0] clr_vec, // Clear strobes, one per bit
    output logic [W-1:0] flags // Sticky event flags
);
    import lirq_pkg::*;

    // A set in the clearing cycle wins, so no event is lost
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            flags <= '0;
        end else begin
            flags <= ((flags & ~clr_vec) | set_vec) & IMPL;
        end
    end
endmodule : lirq_event_bank

// ---- core/lirq_status_top.sv ----
// Loop-zero event status bank with APB access and interrupt
//
// What this block does
// - Frequency lock detector locked-to-unlocked sets lock event bit 3.
// - Frequency lock detector unlocked-to-locked sets lock event bit 2.
// - Phase lock detector locked-to-unlocked sets lock event bit 1.
// - Phase lock detector unlocked-to-locked sets lock event bit 0.
// - Frequency clamp on sets bit 6, off sets bit 7.
// - Phase slew limiter on sets bit 4, off sets bit 5.
// - Reference switch bit 7, freerun bit 6, holdover bit 5 of state.
// - Hitless entry sets state bit 4, hitless exit sets bit 3.
// - Holdover history update sets state bit 2.
// - Phase step sets state bit 0; bit 1 reserved.
// - Feedback divider resync sets acquisition bit 4; bits 7:5 and 1:0 reserved.
// - Fast acquisition start sets bit 2, completion sets bit 3.
// - Activating profile n sets profile bit n, n from 0 to 5.
// - Distribution sync sets analog loop bit 4; bits 7:5 reserved.
// - Analog lock lost sets bit 3, lock gained sets bit 2.
// - Calibration start sets analog bit 0, completion sets bit 1.
// - Event registers read only, all resetting to zero.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module lirq_status_top (
    input wire logic core_clk, // 250 MHz core clock
    input wire logic rstn, // Synchronous reset, active low
    // APB slave
    input wire logic psel, // Slave select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write when high
    input wire logic [lirq_pkg::APB_AW-1:0] paddr, // Byte address
    input wire logic [lirq_pkg::APB_DW-1:0] pwdata, // Write data
    input wire logic [3:0] pstrb, // Write byte strobes
    output logic [lirq_pkg::APB_DW-1:0] prdata, // Read data
    output logic pready, // Always ready
    output logic pslverr, // Unmapped access
    // Loop-zero status levels
    input wire logic phase_lock_detector, // Phase locked level
    input wire logic frequency_lock_detector, // Frequency locked level
    input wire logic clamp_active, // Frequency clamp engaged
    input wire logic slew_active, // Phase slew limiter engaged
    input wire logic hitless_active, // Hitless mode level
    input wire logic fast_acq_active, // Fast acquisition running
    input wire logic analog_lock, // Analog loop locked level
    input wire logic cal_active, // Analog calibration running
    // Loop-zero event pulses
    input wire logic ref_switch_pulse, // Reference input switched
    input wire logic freerun_pulse, // Freerun entered
    input wire logic holdover_pulse, // Holdover entered
    input wire logic history_pulse, // Holdover history updated
    input wire logic phase_step_pulse, // Phase step detected
    input wire logic ndiv_resync_pulse, // Feedback divider resynced
    input wire logic dist_sync_pulse, // Clock distribution synced
    input wire logic profile_pulse, // Profile activated
    input wire logic [lirq_pkg::PROF_SEL_W-1:0] profile_sel, // Its number
    output logic irq // Level interrupt
);
    import lirq_pkg::*;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////
    // Level history for edge detection

    logic prev_pld;
    logic prev_fld;
    logic prev_clamp;
    logic prev_slew;
    logic prev_hitless;
    logic prev_fast;
    logic prev_alock;
    logic prev_cal;

    // Levels start as zero, so a detector already high at release
    // reports one rising event
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            prev_pld <= 1'b0;
            prev_fld <= 1'b0;
            prev_clamp <= 1'b0;
            prev_slew <= 1'b0;
            prev_hitless <= 1'b0;
            prev_fast <= 1'b0;
            prev_alock <= 1'b0;
            prev_cal <= 1'b0;
        end else begin
            prev_pld <= phase_lock_detector;
            prev_fld <= frequency_lock_detector;
            prev_clamp <= clamp_active;
            prev_slew <= slew_active;
            prev_hitless <= hitless_active;
            prev_fast <= fast_acq_active;
            prev_alock <= analog_lock;
            prev_cal <= cal_active;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Event set vectors

    logic [EV_W-1:0] set_vec [NUM_BANKS];
    logic [EV_W-1:0] clr_vec [NUM_BANKS];
    logic [EV_W-1:0] ev [NUM_BANKS];
    logic [EV_W-1:0] mask [NUM_BANKS];

    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            set_vec[b] = '0;
        end
        set_vec[BANK_LOCK][B_FR_UNLOCKED] =
            prev_fld & ~frequency_lock_detector;
        set_vec[BANK_LOCK][B_FR_LOCKED] =
            ~prev_fld & frequency_lock_detector;
        set_vec[BANK_LOCK][B_PH_UNLOCKED] =
            prev_pld & ~phase_lock_detector;
        set_vec[BANK_LOCK][B_PH_LOCKED] =
            ~prev_pld & phase_lock_detector;
        set_vec[BANK_LOCK][B_CLAMP_ON] = ~prev_clamp & clamp_active;
        set_vec[BANK_LOCK][B_CLAMP_OFF] = prev_clamp & ~clamp_active;
        set_vec[BANK_LOCK][B_SLEW_ON] = ~prev_slew & slew_active;
        set_vec[BANK_LOCK][B_SLEW_OFF] = prev_slew & ~slew_active;
        set_vec[BANK_STATE][B_REF_SWITCH] = ref_switch_pulse;
        set_vec[BANK_STATE][B_FREERUN] = freerun_pulse;
        set_vec[BANK_STATE][B_HOLDOVER] = holdover_pulse;
        set_vec[BANK_STATE][B_HITLESS_ON] =
            ~prev_hitless & hitless_active;
        set_vec[BANK_STATE][B_HITLESS_OFF] =
            prev_hitless & ~hitless_active;
        set_vec[BANK_STATE][B_HISTORY] = history_pulse;
        set_vec[BANK_STATE][B_PH_STEP] = phase_step_pulse;
        set_vec[BANK_ACQ][B_NDIV_RESYNC] = ndiv_resync_pulse;
        set_vec[BANK_ACQ][B_FAST_START] = ~prev_fast & fast_acq_active;
        set_vec[BANK_ACQ][B_FAST_DONE] = prev_fast & ~fast_acq_active;
        // Profile numbers 6 and 7 do not exist and are dropped
        if (profile_pulse && profile_sel < PROF_SEL_W'(PROF_COUNT)) begin
            set_vec[BANK_PROF][profile_sel] = 1'b1;
        end
        set_vec[BANK_ANA][B_DIST_SYNC] = dist_sync_pulse;
        set_vec[BANK_ANA][B_AUNLOCK] = prev_alock & ~analog_lock;
        set_vec[BANK_ANA][B_ALOCK] = ~prev_alock & analog_lock;
        set_vec[BANK_ANA][B_CAL_START] = ~prev_cal & cal_active;
        set_vec[BANK_ANA][B_CAL_DONE] = prev_cal & ~cal_active;
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky banks

    localparam logic [EV_W-1:0] IMPL_TAB [NUM_BANKS] =
        '{IMPL_LOCK, IMPL_STATE, IMPL_ACQ, IMPL_PROF, IMPL_ANA};

    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
        lirq_event_bank #(
            .W(EV_W),
            .IMPL(IMPL_TAB[g])
        ) u_bank (
            .core_clk(core_clk),
            .rstn(rstn),
            .set_vec(set_vec[g]),
            .clr_vec(clr_vec[g]),
            .flags(ev[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // APB decode

    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] ev_off;
    logic [IDX_W-1:0] mask_off;
    logic [IDX_W-1:0] clr_off;
    logic hit_ev;
    logic hit_mask;
    logic hit_clr;
    logic hit_pend;
    logic setup;
    logic wr_acc;
    logic [EV_W-1:0] pend;

    assign idx = paddr[APB_AW-1:2];
    assign ev_off = idx - IDX_LOCK;
    assign mask_off = idx - IDX_MASK_BASE;
    assign clr_off = idx - IDX_CLR_BASE;
    assign hit_ev = idx >= IDX_LOCK && ev_off < IDX_W'(NUM_BANKS);
    assign hit_mask = idx >= IDX_MASK_BASE && mask_off < IDX_W'(NUM_BANKS);
    assign hit_clr = idx >= IDX_CLR_BASE && clr_off < IDX_W'(NUM_BANKS);
    assign hit_pend = idx == IDX_PEND;
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && pstrb[0];
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;

    // Writes to the event registers are ignored
    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            clr_vec[b] = '0;
        end
        if (wr_acc && hit_clr) begin
            clr_vec[clr_off[2:0]] = pwdata[EV_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int b = 0; b < NUM_BANKS; b++) begin
                mask[b] <= MASK_RESET;
            end
        end else if (wr_acc && hit_mask) begin
            mask[mask_off[2:0]] <= pwdata[EV_W-1:0] & IMPL_TAB[mask_off[2:0]];
        end
    end

    // Read data captured in the setup cycle, one cycle before the sample
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= !(hit_ev || hit_mask || hit_clr || hit_pend);
            if (pwrite) begin
                prdata <= '0;
            end else if (hit_ev) begin
                prdata <= {{(APB_DW-EV_W){1'b0}}, ev[ev_off[2:0]]};
            end else if (hit_mask) begin
                prdata <= {{(APB_DW-EV_W){1'b0}}, mask[mask_off[2:0]]};
            end else if (hit_pend) begin
                prdata <= {{(APB_DW-EV_W){1'b0}}, pend};
            end else begin
                prdata <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt

    always_comb begin
        pend = '0;
        for (int b = 0; b < NUM_BANKS; b++) begin
            pend[b] = |(ev[b] & mask[b]);
        end
    end

    // Registered to keep the pin glitch free; one cycle behind pend
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |pend;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    logic clr_lock_any;
    assign clr_lock_any = wr_acc && hit_clr && clr_off == '0;

    AST_FR_UNLOCK: assert property (
        $fell(frequency_lock_detector) |=> ev[BANK_LOCK][B_FR_UNLOCKED])
        else $error("frequency unlock event not recorded");

    AST_FR_LOCK: assert property (
        $rose(frequency_lock_detector) |=> ev[BANK_LOCK][B_FR_LOCKED])
        else $error("frequency lock event not recorded");

    AST_PH_UNLOCK: assert property (
        $fell(phase_lock_detector) |=> ev[BANK_LOCK][B_PH_UNLOCKED])
        else $error("phase unlock event not recorded");

    AST_PH_LOCK: assert property (
        $rose(phase_lock_detector) |=> ev[BANK_LOCK][B_PH_LOCKED])
        else $error("phase lock event not recorded");

    AST_CLAMP: assert property (
        $rose(clamp_active) |=> ev[BANK_LOCK][B_CLAMP_ON]
            && $stable(ev[BANK_LOCK][B_CLAMP_OFF]) || $past(clr_lock_any))
        else $error("clamp activation mis-recorded");

    AST_SLEW: assert property (
        $fell(slew_active) |=> ev[BANK_LOCK][B_SLEW_OFF])
        else $error("slew limiter release not recorded");

    AST_STATE_PULSE: assert property (
        ref_switch_pulse && freerun_pulse && holdover_pulse
            |=> ev[BANK_STATE][7:5] == 3'h7)
        else $error("state pulses not recorded");

    AST_HITLESS: assert property (
        $fell(hitless_active) |=> ev[BANK_STATE][B_HITLESS_OFF])
        else $error("hitless exit not recorded");

    AST_HISTORY: assert property (
        history_pulse |=> ev[BANK_STATE][B_HISTORY])
        else $error("history update not recorded");

    AST_RESERVED: assert property (
        ev[BANK_STATE][1] == 1'b0 && ev[BANK_ACQ][7:5] == 3'h0
            && ev[BANK_ACQ][1:0] == 2'h0 && ev[BANK_PROF][7:6] == 2'h0
            && ev[BANK_ANA][7:5] == 3'h0)
        else $error("reserved event bit set");

    AST_FAST: assert property (
        $rose(fast_acq_active) ##1 $fell(fast_acq_active)
            |=> ev[BANK_ACQ][3:2] == 2'h3 || $past(wr_acc && hit_clr, 2))
        else $error("fast acquisition pair not recorded");

    AST_PROFILE: assert property (
        profile_pulse && profile_sel == 3'h5 |=> ev[BANK_PROF][5])
        else $error("profile 5 activation not recorded");

    AST_ANALOG: assert property (
        $fell(analog_lock) |=> ev[BANK_ANA][B_AUNLOCK])
        else $error("analog unlock not recorded");

    AST_CAL: assert property (
        $rose(cal_active) |=> ev[BANK_ANA][B_CAL_START])
        else $error("calibration start not recorded");

    // Checked at the first edge after release; during reset it is disabled
    AST_RESET_ZERO: assert property (
        @(posedge core_clk) $rose(rstn) |-> ev[BANK_LOCK] == 8'h00
            && ev[BANK_STATE] == 8'h00 && ev[BANK_ACQ] == 8'h00
            && ev[BANK_PROF] == 8'h00 && ev[BANK_ANA] == 8'h00)
        else $error("event register not zero after reset");

    AST_STICKY: assert property (
        ev[BANK_LOCK][B_FR_LOCKED] && !clr_lock_any
            |=> ev[BANK_LOCK][B_FR_LOCKED])
        else $error("lock event dropped without clear");

    AST_SET_WINS: assert property (
        clr_lock_any && set_vec[BANK_LOCK][B_PH_LOCKED]
            |=> ev[BANK_LOCK][B_PH_LOCKED])
        else $error("event lost in clearing cycle");

    AST_CLEAR: assert property (
        clr_lock_any && pwdata[B_FR_LOCKED]
            && !set_vec[BANK_LOCK][B_FR_LOCKED]
            |=> !ev[BANK_LOCK][B_FR_LOCKED])
        else $error("lock event survived its clear");

    AST_IRQ: assert property (
        |pend |=> irq)
        else $error("interrupt missing for pending event");

    AST_IRQ_LOW: assert property (
        !(|pend) |=> !irq)
        else $error("interrupt raised with nothing pending");
endmodule : lirq_status_top

// ---- verification/tb_top.sv ----
// Self-checking bench for the loop-zero event status bank
`timescale 1ns/1ps
module tb_top;
    import lirq_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 16'h0000;
    logic [APB_DW-1:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [3:0] strb = 4'hF;
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [7:0] lv = 8'h00;
    logic [6:0] pv = 7'h00;
    logic profile_pulse = 1'b0;
    logic [PROF_SEL_W-1:0] profile_sel = 3'h0;
    logic [31:0] d;
    logic e;
    int n_fail = 0;
    int n_checks = 0;
    // Levels: phase, freq, clamp, slew, hitless, fast acq, analog, cal
    int lv_bank [8] = '{0, 0, 0, 0, 1, 2, 4, 4};
    int lv_rise [8] = '{0, 2, 6, 4, 4, 2, 2, 0};
    int lv_fall [8] = '{1, 3, 7, 5, 3, 3, 3, 1};
    // Pulses: ref switch, freerun, holdover, history, step, resync, sync
    int pv_bank [7] = '{1, 1, 1, 1, 1, 2, 4};
    int pv_bit [7] = '{7, 6, 5, 2, 0, 4, 4};

    always #2 core_clk = ~core_clk;

    lirq_status_top lirq_status_top_i (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_lock_detector(lv[0]), .frequency_lock_detector(lv[1]),
        .clamp_active(lv[2]), .slew_active(lv[3]), .hitless_active(lv[4]),
        .fast_acq_active(lv[5]), .analog_lock(lv[6]), .cal_active(lv[7]),
        .ref_switch_pulse(pv[0]), .freerun_pulse(pv[1]),
        .holdover_pulse(pv[2]), .history_pulse(pv[3]),
        .phase_step_pulse(pv[4]), .ndiv_resync_pulse(pv[5]),
        .dist_sync_pulse(pv[6]), .profile_pulse(profile_pulse),
        .profile_sel(profile_sel), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk

    // One APB transfer; read data and error land in d and e
    task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
                       input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= strb;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a stalled access
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_ev(input int b);
        apb(1'b0, IDX_LOCK + IDX_W'(b), 32'h0000_0000);
    endtask : rd_ev

    task automatic clr(input int b);
        apb(1'b1, IDX_CLR_BASE + IDX_W'(b), 32'h0000_00FF);
    endtask : clr

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        int b;
        for (b = 0; b < NUM_BANKS; b++) begin
            rd_ev(b);
            chk("event reset", 32'h0000_0000, d);
            chk("event error", 32'h0000_0000, {31'h0, e});
        end
        $display("t_reset done");
    endtask : t_reset

    // Each level edge sets exactly its own bit, then clears on request
    task automatic t_levels();
        int i;
        logic [31:0] x;
        for (i = 0; i < 8; i++) begin
            @(posedge core_clk);
            lv[i] <= 1'b1;
            tick(3);
            rd_ev(lv_bank[i]);
            x = 32'h1 << lv_rise[i];
            chk("rise", x, d);
            clr(lv_bank[i]);
            rd_ev(lv_bank[i]);
            chk("rise cleared", 32'h0000_0000, d);
            @(posedge core_clk);
            lv[i] <= 1'b0;
            tick(3);
            rd_ev(lv_bank[i]);
            x = 32'h1 << lv_fall[i];
            chk("fall", x, d);
            clr(lv_bank[i]);
        end
        $display("t_levels done");
    endtask : t_levels

    // One-cycle pulses must leave a sticky bit behind
    task automatic t_pulses();
        int i;
        logic [31:0] x;
        for (i = 0; i < 7; i++) begin
            @(posedge core_clk);
            pv[i] <= 1'b1;
            @(posedge core_clk);
            pv[i] <= 1'b0;
            tick(3);
            x = 32'h1 << pv_bit[i];
            rd_ev(pv_bank[i]);
            chk("pulse", x, d);
            rd_ev(pv_bank[i]);
            chk("pulse reread", x, d);
            clr(pv_bank[i]);
        end
        $display("t_pulses done");
    endtask : t_pulses

    // Profiles 6 and 7 have no bit and must leave the bank empty
    task automatic t_prof();
        int n;
        logic [31:0] x;
        for (n = 0; n < 8; n++) begin
            @(posedge core_clk);
            profile_sel <= PROF_SEL_W'(n);
            profile_pulse <= 1'b1;
            @(posedge core_clk);
            profile_pulse <= 1'b0;
            tick(3);
            x = (n < PROF_COUNT) ? (32'h1 << n) : 32'h0000_0000;
            rd_ev(BANK_PROF);
            chk("profile", x, d);
            clr(BANK_PROF);
        end
        $display("t_prof done");
    endtask : t_prof

    // Writes to event registers are ignored; reset clears mid-run
    task automatic t_ro();
        @(posedge core_clk);
        pv[2] <= 1'b1;
        @(posedge core_clk);
        pv[2] <= 1'b0;
        apb(1'b1, IDX_STATE, 32'h0000_0000);
        chk("ro write error", 32'h0000_0000, {31'h0, e});
        rd_ev(BANK_STATE);
        chk("ro kept", 32'h0000_0020, d);
        apb(1'b1, IDX_LOCK, 32'h0000_00FF);
        rd_ev(BANK_LOCK);
        chk("ro no set", 32'h0000_0000, d);
        apb(1'b0, 14'h3100, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, e});
        chk("unmapped data", 32'h0000_0000, d);
        apb(1'b0, IDX_CLR_BASE, 32'h0000_0000);
        chk("clear reads zero", 32'h0000_0000, d);
        chk("clear read error", 32'h0000_0000, {31'h0, e});
        @(posedge core_clk);
        rstn <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        rd_ev(BANK_STATE);
        chk("second reset", 32'h0000_0000, d);
        $display("t_ro done");
    endtask : t_ro

    // Simultaneous pulses, a one-cycle fast acquisition, set beats clear
    task automatic t_pair();
        @(posedge core_clk);
        pv[2:0] <= 3'h7;
        lv[5] <= 1'b1;
        @(posedge core_clk);
        pv[2:0] <= 3'h0;
        lv[5] <= 1'b0;
        tick(3);
        rd_ev(BANK_STATE);
        chk("pulses together", 32'h0000_00E0, d);
        rd_ev(BANK_ACQ);
        chk("fast pair", 32'h0000_000C, d);
        clr(BANK_STATE);
        clr(BANK_ACQ);
        // Phase lock edge lands on the clearing access edge
        fork
            clr(BANK_LOCK);
            begin
                tick(2);
                lv[0] <= 1'b1;
            end
        join
        rd_ev(BANK_LOCK);
        chk("set wins", 32'h0000_0001, d);
        @(posedge core_clk);
        lv[0] <= 1'b0;
        tick(3);
        rd_ev(BANK_LOCK);
        chk("set kept", 32'h0000_0003, d);
        clr(BANK_LOCK);
        $display("t_pair done");
    endtask : t_pair

    // A high mask bit lets its bank reach irq; reset leaves all masked
    task automatic t_irq();
        @(posedge core_clk);
        pv[0] <= 1'b1;
        @(posedge core_clk);
        pv[0] <= 1'b0;
        tick(3);
        #1;
        chk("irq off at reset", 32'h0000_0000, {31'h0, irq});
        strb = 4'hE;
        apb(1'b1, IDX_MASK_BASE + 14'h0001, 32'h0000_00FF);
        strb = 4'hF;
        apb(1'b0, IDX_MASK_BASE + 14'h0001, 32'h0000_0000);
        chk("mask without strobe", 32'h0000_0000, d);
        apb(1'b1, IDX_MASK_BASE + 14'h0001, 32'h0000_00FF);
        apb(1'b0, IDX_MASK_BASE + 14'h0001, 32'h0000_0000);
        chk("mask readback", 32'h0000_00FD, d);
        tick(3);
        #1;
        chk("irq enabled", 32'h0000_0001, {31'h0, irq});
        apb(1'b0, IDX_PEND, 32'h0000_0000);
        chk("pending", 32'h0000_0002, d);
        apb(1'b1, IDX_MASK_BASE + 14'h0001, 32'h0000_0000);
        tick(3);
        #1;
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        rd_ev(BANK_STATE);
        chk("masked kept", 32'h0000_0080, d);
        apb(1'b1, IDX_MASK_BASE + 14'h0001, 32'h0000_00FF);
        clr(BANK_STATE);
        tick(3);
        #1;
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        $display("t_irq done");
    endtask : t_irq

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // Whole run is a few hundred cycles; this leaves ample margin
    initial begin
        #100000;
        n_fail++;
        conclude();
    end

    initial begin
        tick(20);
        rstn <= 1'b1;
        t_reset();
        t_levels();
        t_pulses();
        t_prof();
        t_ro();
        t_pair();
        t_irq();
        conclude();
    end
endmodule : tb_top
